// ### rtl/wsu_pkg.sv
package wsu_pkg;

  // ****************************************************************
  // Sizes of the wedge
  // ****************************************************************
  localparam int NUM_FINDERS = 6;
  localparam int CANDS_PER_FINDER = 2;
  localparam int NUM_CANDS = NUM_FINDERS * CANDS_PER_FINDER;
  localparam int NUM_PAIRS = 6;
  localparam int QUAL_W = 3;
  localparam int PT_W = 5;
  localparam int PHI_W = 8;
  localparam int ETA_W = 6;
  localparam int SEG_W = 4;
  localparam int PRIO_W = 3;
  localparam int KEY_W = PRIO_W + PT_W;

  // Finder pairs on consecutive wheels, lower eta first; finders 2 and 3 share the central wheel
  localparam int PAIR_LO [NUM_PAIRS] = '{0, 1, 1, 2, 3, 4};
  localparam int PAIR_HI [NUM_PAIRS] = '{1, 2, 3, 4, 4, 5};

  // Empty candidate and unused segment codes
  localparam logic [QUAL_W-1:0] QUAL_NONE = 3'h0;
  localparam logic [SEG_W-1:0] SEG_NONE = 4'h0;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_TRK_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FND_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PRIO_MAP = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_OUT_CNT = 8'h14;

  localparam int CTRL_FILT_EN_BIT = 0;
  localparam int CTRL_MINQ_LSB = 4;
  localparam int CTRL_WIN_LSB = 8;
  localparam int STAT_BUF_FULL_BIT = 12;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0120;
  localparam logic [31:0] PRIO_RESET = 32'h00FA_C688;

  // ****************************************************************
  // Carried words
  // ****************************************************************
  typedef struct packed {
    logic [ETA_W-1:0]  eta;
    logic              charge;
    logic [PHI_W-1:0]  phi;
    logic [PT_W-1:0]   pt;
    logic [QUAL_W-1:0] quality;
  } wsu_track_type;

  typedef struct packed {
    logic [SEG_W-1:0] st4;
    logic [SEG_W-1:0] st3;
  } wsu_seg_type;

  typedef struct packed {
    logic [NUM_CANDS-1:0] best_sel;
    logic [NUM_CANDS-1:0] second_sel;
    wsu_track_type        best;
    wsu_track_type        second;
  } wsu_result_type;

endpackage : wsu_pkg

// ### rtl/wsu_rank_unit.sv
`timescale 1ns/1ps
module wsu_rank_unit
  import wsu_pkg::*;
#(
  parameter int N = NUM_CANDS
) (
  // Candidates
  input  wire logic [N-1:0]            cand_en,
  input  wire logic [N-1:0][KEY_W-1:0] cand_key,
  // One-hot winners
  output logic      [N-1:0]            first_sel,
  output logic      [N-1:0]            next_sel
);

  localparam int CNT_W = $clog2(N) + 1;

  logic [N-1:0][N-1:0] beats;
  logic [N-1:0][CNT_W-1:0] losses;

  // ****************************************************************
  // Pairwise comparators, one per unordered pair
  // ****************************************************************
  for (genvar gi = 0; gi < N; gi++) begin : g_row
    for (genvar gj = 0; gj < N; gj++) begin : g_col
      if (gi < gj) begin : g_cmp
        // Equal keys go to the lower index so the order is total
        assign beats[gi][gj] = cand_en[gi] & (~cand_en[gj] | (cand_key[gi] >= cand_key[gj]));
        assign beats[gj][gi] = cand_en[gj] & ~beats[gi][gj];
      end else if (gi == gj) begin : g_self
        assign beats[gi][gj] = 1'b0;
      end
    end
  end

  // Rank is the number of candidates that outrank this one
  always_comb begin
    for (int i = 0; i < N; i++) begin
      losses[i] = '0;
      for (int j = 0; j < N; j++) begin
        losses[i] = losses[i] + CNT_W'(beats[j][i]);
      end
      first_sel[i] = cand_en[i] & (losses[i] == CNT_W'(0));
      next_sel[i]  = cand_en[i] & (losses[i] == CNT_W'(1));
    end
  end

endmodule : wsu_rank_unit

// ### rtl/wsu_wedge_sorter.sv
// Operation
// - Shared segment marks worse or higher-eta track
// - Close phi marks worse or higher-eta track
// - Optional low-quality filter disables ghost candidates
// - Tagger yields twelve disables to sorting
// - Tagger, track mask, finder mask exclude candidates
// - Rank by quality, then transverse momentum
// - Sixty-six parallel pairwise comparators build ranking
// - Quality mapped to priority by configuration
// - Two one-hot twelve-line select groups
// - Track data pipelined, muxed by selects
// - Segment addresses arrive one cycle early
// - Two cycles from track data to output
// - Everything runs on one sorter clock
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module wsu_wedge_sorter
  import wsu_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input  wire logic                           REF_CLK,
  input  wire logic                           RESET,
  // APB slave
  input  wire logic                           PSEL,
  input  wire logic                           PENABLE,
  input  wire logic                           PWRITE,
  input  wire logic [ADDR_W-1:0]              PADDR,
  input  wire logic [31:0]                    PWDATA,
  output logic      [31:0]                    PRDATA,
  output logic                                PREADY,
  output logic                                PSLVERR,
  // Finder inputs
  input  wire wsu_seg_type   [NUM_CANDS-1:0]  SEG_ADDR,
  input  wire wsu_track_type [NUM_CANDS-1:0]  TRACK_DATA,
  input  wire logic                           TRACK_VALID,
  output logic                                TRACK_READY,
  // Sorted output
  output logic      [NUM_CANDS-1:0]           BEST_SEL,
  output logic      [NUM_CANDS-1:0]           SECOND_SEL,
  output wsu_track_type                       BEST_TRACK,
  output wsu_track_type                       SECOND_TRACK,
  output logic                                OUT_VALID,
  input  wire logic                           OUT_READY
);

  localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CNT_W = $clog2(BUF_DEPTH + 1);
  localparam logic [NUM_CANDS-1:0] ONE_HOT0 = 12'h001;

  logic [31:0] ctrl_q;
  logic [NUM_CANDS-1:0] trk_mask_q;
  logic [NUM_FINDERS-1:0] fnd_mask_q;
  logic [31:0] prio_q;
  logic [15:0] out_cnt_q;
  logic [NUM_CANDS-1:0] last_dis_q;
  logic apb_wr;
  logic apb_hit;

  logic adv;
  wsu_seg_type [NUM_CANDS-1:0] seg_q;
  wsu_track_type [NUM_CANDS-1:0] trk_q;
  logic valid1_q;
  logic [NUM_CANDS-1:0] dis_d;
  logic [NUM_CANDS-1:0] dis_q;
  logic [NUM_PAIRS*4-1:0][NUM_CANDS-1:0] dup_vec;
  logic [NUM_CANDS-1:0] low_q;
  logic filt_en;
  logic [QUAL_W-1:0] min_qual;
  logic [PHI_W-1:0] phi_win;

  logic [NUM_CANDS-1:0] cand_en;
  logic [NUM_CANDS-1:0][KEY_W-1:0] cand_key;
  logic [NUM_CANDS-1:0] best_sel;
  logic [NUM_CANDS-1:0] second_sel;
  wsu_result_type res_d;
  // Helpers read only by the checks
  logic [NUM_CANDS-1:0] fnd_mask_exp;
  logic [KEY_W-1:0] best_key;
  logic [KEY_W-1:0] second_key;

  wsu_result_type buf_mem [BUF_DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] buf_cnt_q;
  logic push;
  logic pop;

  // ****************************************************************
  // APB register file
  // ****************************************************************
  assign filt_en  = ctrl_q[CTRL_FILT_EN_BIT];
  assign min_qual = ctrl_q[CTRL_MINQ_LSB +: QUAL_W];
  assign phi_win  = ctrl_q[CTRL_WIN_LSB +: PHI_W];
  assign apb_wr   = PSEL & PENABLE & PWRITE;
  assign PREADY   = 1'b1;

  // Address decode; unmapped offsets read zero and flag an error
  always_comb begin
    apb_hit = 1'b1;
    PRDATA  = 32'h0000_0000;
    unique case (PADDR)
      OFF_CTRL:     PRDATA = ctrl_q;
      OFF_TRK_MASK: PRDATA = {20'h0_0000, trk_mask_q};
      OFF_FND_MASK: PRDATA = {26'h000_0000, fnd_mask_q};
      OFF_PRIO_MAP: PRDATA = prio_q;
      OFF_STATUS:   PRDATA = {19'h0_0000, (buf_cnt_q == CNT_W'(BUF_DEPTH)), last_dis_q};
      OFF_OUT_CNT:  PRDATA = {16'h0000, out_cnt_q};
      default:      apb_hit = 1'b0;
    endcase
  end
  assign PSLVERR = PSEL & PENABLE & ~apb_hit;

  // Configuration writes; status offsets ignore writes
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ctrl_q     <= CTRL_RESET;
      trk_mask_q <= '0;
      fnd_mask_q <= '0;
      prio_q     <= PRIO_RESET;
    end else if (apb_wr) begin
      if (PADDR == OFF_CTRL)     ctrl_q     <= PWDATA;
      if (PADDR == OFF_TRK_MASK) trk_mask_q <= PWDATA[NUM_CANDS-1:0];
      if (PADDR == OFF_FND_MASK) fnd_mask_q <= PWDATA[NUM_FINDERS-1:0];
      if (PADDR == OFF_PRIO_MAP) prio_q     <= PWDATA;
    end
  end

  // Diagnostics: count of results pushed into the buffer and last tagger verdict
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      out_cnt_q  <= '0;
      last_dis_q <= '0;
    end else if (push) begin
      out_cnt_q  <= out_cnt_q + 16'h0001;
      last_dis_q <= dis_q;
    end
  end

  // ****************************************************************
  // Input stage: addresses one cycle ahead of track data
  // ****************************************************************
  // A full output buffer freezes the whole pipe so no word is lost
  assign adv = (buf_cnt_q != CNT_W'(BUF_DEPTH));
  assign TRACK_READY = adv;

  // Addresses are latched early so tagging overlaps the finders' last step
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      seg_q <= '0;
    end else if (adv) begin
      seg_q <= SEG_ADDR;
    end
  end

  // Track data and tagger verdicts enter the first pipe stage together
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      trk_q    <= '0;
      dis_q    <= '0;
      valid1_q <= 1'b0;
    end else if (adv) begin
      trk_q    <= TRACK_DATA;
      dis_q    <= dis_d;
      valid1_q <= TRACK_VALID;
    end
  end

  // ****************************************************************
  // Duplicate tagging between consecutive wheels
  // ****************************************************************
  for (genvar gp = 0; gp < NUM_PAIRS; gp++) begin : g_pair
    for (genvar ga = 0; ga < CANDS_PER_FINDER; ga++) begin : g_a
      for (genvar gb = 0; gb < CANDS_PER_FINDER; gb++) begin : g_b
        localparam int IA = CANDS_PER_FINDER * PAIR_LO[gp] + ga;
        localparam int IB = CANDS_PER_FINDER * PAIR_HI[gp] + gb;
        logic shared;
        logic split;
        logic live;
        logic [PHI_W-1:0] dphi;
        // Shared segment in station three or four
        assign shared = ((seg_q[IA].st3 == seg_q[IB].st3) && (seg_q[IA].st3 != SEG_NONE)) ||
                        ((seg_q[IA].st4 == seg_q[IB].st4) && (seg_q[IA].st4 != SEG_NONE));
        // Split short tracks sit close in phi
        assign dphi  = (TRACK_DATA[IA].phi > TRACK_DATA[IB].phi) ?
                       (TRACK_DATA[IA].phi - TRACK_DATA[IB].phi) :
                       (TRACK_DATA[IB].phi - TRACK_DATA[IA].phi);
        assign split = (dphi <= phi_win);
        assign live  = (TRACK_DATA[IA].quality != QUAL_NONE) &&
                       (TRACK_DATA[IB].quality != QUAL_NONE);
        // Worse quality loses; a tie goes against the larger-eta finder
        assign dup_vec[(gp * 4) + (ga * 2) + gb] = (live && (shared || split)) ?
          ((TRACK_DATA[IA].quality < TRACK_DATA[IB].quality) ? (ONE_HOT0 << IA) :
                                                               (ONE_HOT0 << IB)) :
          '0;
      end
    end
  end

  // Ghost filter against low-quality candidates
  for (genvar gc = 0; gc < NUM_CANDS; gc++) begin : g_low
    assign low_q[gc] = filt_en && (TRACK_DATA[gc].quality != QUAL_NONE) &&
                       (TRACK_DATA[gc].quality < min_qual);
  end

  // Merge all verdicts into one disable per candidate
  always_comb begin
    dis_d = low_q;
    for (int k = 0; k < NUM_PAIRS * 4; k++) begin
      dis_d = dis_d | dup_vec[k];
    end
  end

  // ****************************************************************
  // Mask and sort
  // ****************************************************************
  for (genvar gc = 0; gc < NUM_CANDS; gc++) begin : g_cand
    // Empty slots never compete
    assign cand_en[gc] = valid1_q && (trk_q[gc].quality != QUAL_NONE) && !dis_q[gc] &&
                         !trk_mask_q[gc] && !fnd_mask_q[gc / CANDS_PER_FINDER];
    // Priority first, momentum breaks ties
    assign cand_key[gc] = {prio_q[int'(trk_q[gc].quality) * PRIO_W +: PRIO_W],
                           trk_q[gc].pt};
    // Finder mask spread to its candidates, for the checks
    assign fnd_mask_exp[gc] = fnd_mask_q[gc / CANDS_PER_FINDER];
  end

  wsu_rank_unit #(
    .N (NUM_CANDS)
  ) u_rank (
    .cand_en   (cand_en),
    .cand_key  (cand_key),
    .first_sel (best_sel),
    .next_sel  (second_sel)
  );

  // AND-OR multiplexers; no select gives an all-zero track
  always_comb begin
    res_d            = '0;
    res_d.best_sel   = best_sel;
    res_d.second_sel = second_sel;
    best_key         = '0;
    second_key       = '0;
    for (int c = 0; c < NUM_CANDS; c++) begin
      res_d.best   = res_d.best | (best_sel[c] ? trk_q[c] : '0);
      res_d.second = res_d.second | (second_sel[c] ? trk_q[c] : '0);
      best_key     = best_key | (best_sel[c] ? cand_key[c] : '0);
      second_key   = second_key | (second_sel[c] ? cand_key[c] : '0);
    end
  end

  // ****************************************************************
  // Output buffer, second pipe stage
  // ****************************************************************
  assign push = valid1_q & adv;
  assign pop  = OUT_VALID & OUT_READY;

  // Entries hold the result of one crossing
  always_ff @(posedge REF_CLK) begin
    if (push) begin
      buf_mem[wr_ptr_q] <= res_d;
    end
  end

  // Pointers and fill level; every register on the one clock
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      wr_ptr_q  <= '0;
      rd_ptr_q  <= '0;
      buf_cnt_q <= '0;
    end else begin
      if (push) wr_ptr_q <= (wr_ptr_q == PTR_W'(BUF_DEPTH - 1)) ? '0 : wr_ptr_q + PTR_W'(1);
      if (pop)  rd_ptr_q <= (rd_ptr_q == PTR_W'(BUF_DEPTH - 1)) ? '0 : rd_ptr_q + PTR_W'(1);
      buf_cnt_q <= buf_cnt_q + CNT_W'(push) - CNT_W'(pop);
    end
  end

  // Outputs are read straight from buffer flops
  assign OUT_VALID    = (buf_cnt_q != '0);
  assign BEST_SEL     = OUT_VALID ? buf_mem[rd_ptr_q].best_sel : '0;
  assign SECOND_SEL   = OUT_VALID ? buf_mem[rd_ptr_q].second_sel : '0;
  assign BEST_TRACK   = OUT_VALID ? buf_mem[rd_ptr_q].best : '0;
  assign SECOND_TRACK = OUT_VALID ? buf_mem[rd_ptr_q].second : '0;

  // ****************************************************************
  // Checks
  // ****************************************************************
  best_onehot_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    OUT_VALID |-> ($onehot0(BEST_SEL) && $onehot0(SECOND_SEL)))
    else $error("select group not one-hot");

  winners_distinct_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    OUT_VALID |-> ((BEST_SEL & SECOND_SEL) == '0))
    else $error("best and second select the same candidate");

  second_needs_best_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (OUT_VALID && (SECOND_SEL != '0)) |-> (BEST_SEL != '0))
    else $error("second winner without a best winner");

  null_track_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    push |=> ((($past(best_sel) != '0) || (buf_mem[$past(wr_ptr_q)].best == '0)) &&
              (($past(second_sel) != '0) || (buf_mem[$past(wr_ptr_q)].second == '0))))
    else $error("missing winner did not give a null track");

  masked_excluded_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    push |-> (((best_sel | second_sel) & (dis_q | trk_mask_q)) == '0))
    else $error("disabled or masked candidate selected");

  finder_mask_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    push |-> (((best_sel | second_sel) & fnd_mask_exp) == '0))
    else $error("masked finder candidate selected");

  filter_drops_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (adv && TRACK_VALID && (low_q != '0)) |=>
      (((best_sel | second_sel) & $past(low_q)) == '0))
    else $error("low-quality candidate escaped the filter");

  latency_two_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (TRACK_VALID && TRACK_READY && !valid1_q && (buf_cnt_q == '0)) |=> !OUT_VALID ##1 OUT_VALID)
    else $error("result not delivered two cycles after track data");

  second_not_better_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (push && (second_sel != '0)) |-> (best_key >= second_key))
    else $error("second winner outranks best winner");

  push_shows_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    push |=> OUT_VALID)
    else $error("pushed result not offered downstream");

  output_holds_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (OUT_VALID && !OUT_READY) |=> (OUT_VALID && $stable(BEST_SEL) && $stable(SECOND_SEL) &&
                                   $stable(BEST_TRACK) && $stable(SECOND_TRACK)))
    else $error("stalled result changed before it was taken");

  bad_write_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (apb_wr && !apb_hit) |=> ($stable(ctrl_q) && $stable(trk_mask_q) && $stable(fnd_mask_q) &&
                              $stable(prio_q)))
    else $error("unmapped write changed a register");

  stall_holds_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (buf_cnt_q == CNT_W'(BUF_DEPTH)) |-> (!TRACK_READY && !push))
    else $error("full buffer did not stall the pipe");

endmodule : wsu_wedge_sorter

// ### tb/wsu_finder_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Finder side: six finders with two candidates each
// ****************************************************************
module wsu_finder_model
  import wsu_pkg::*;
(
  // Clock and flow control
  input  wire logic                     clk,
  input  wire logic                     track_ready,
  // Words toward the sorter
  output wsu_seg_type   [NUM_CANDS-1:0] seg_addr,
  output wsu_track_type [NUM_CANDS-1:0] track_data,
  output logic                          track_valid
);
  // Idle lines carry a pattern, never a stale word
  initial begin
    seg_addr    = '1;
    track_data  = '1;
    track_valid = 1'b0;
  end

  // Segments lead the track word by one accepted edge
  task automatic send(input wsu_seg_type [NUM_CANDS-1:0] s,
                      input wsu_track_type [NUM_CANDS-1:0] t);
    @(posedge clk);
    seg_addr <= s;
    @(posedge clk);
    while (track_ready !== 1'b1) @(posedge clk);
    track_data  <= t;
    track_valid <= 1'b1;
    @(posedge clk);
    while (track_ready !== 1'b1) @(posedge clk);
    // Inverted after release so a late sample cannot match
    track_valid <= 1'b0;
    track_data  <= ~t;
    seg_addr    <= ~s;
  endtask : send
endmodule : wsu_finder_model

// ### tb/tb.sv
`timescale 1ns/1ps
module tb
  import wsu_pkg::*;
;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic                          ref_clk = 1'b0;
  logic                          reset   = 1'b1;
  logic                          psel    = 1'b0;
  logic                          penable = 1'b0;
  logic                          pwrite  = 1'b0;
  logic [ADDR_W-1:0]             paddr   = '0;
  logic [31:0]                   pwdata  = '0;
  logic [31:0]                   prdata;
  logic                          pready;
  logic                          pslverr;
  wsu_seg_type   [NUM_CANDS-1:0] seg_addr;
  wsu_track_type [NUM_CANDS-1:0] track_data;
  logic                          track_valid;
  logic                          track_ready;
  logic [NUM_CANDS-1:0]          best_sel;
  logic [NUM_CANDS-1:0]          second_sel;
  wsu_track_type                 best_track;
  wsu_track_type                 second_track;
  logic                          out_valid;
  logic                          out_ready = 1'b1;
  wsu_track_type [NUM_CANDS-1:0] tk;
  wsu_seg_type   [NUM_CANDS-1:0] sg;
  logic [31:0]                   rd;
  logic                          er;
  int                            error_cnt = 0;
  int                            checked   = 0;
  int                            cyc       = 0;

  // Device and finder source
  wsu_wedge_sorter wsu_wedge_sorter_i (
    .REF_CLK(ref_clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SEG_ADDR(seg_addr),
    .TRACK_DATA(track_data), .TRACK_VALID(track_valid),
    .TRACK_READY(track_ready), .BEST_SEL(best_sel), .SECOND_SEL(second_sel),
    .BEST_TRACK(best_track), .SECOND_TRACK(second_track),
    .OUT_VALID(out_valid), .OUT_READY(out_ready)
  );
  wsu_finder_model wsu_finder_model_i (
    .clk(ref_clk), .track_ready(track_ready), .seg_addr(seg_addr),
    .track_data(track_data), .track_valid(track_valid)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  always #2 ref_clk = ~ref_clk;

  // Hang guard, far above the hundred-odd cycles needed
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done;
    if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; holds everything until pready is sampled
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Empty candidates, each with its own payload
  task automatic clear;
    for (int i = 0; i < NUM_CANDS; i++) begin
      tk[i]        = '0;
      tk[i].phi    = 8'(i * 20);
      tk[i].pt     = 5'(i);
      tk[i].eta    = 6'(i + 1);
      tk[i].charge = i[0];
      sg[i]        = '0;
    end
  endtask : clear

  // Send one crossing, expect winners b and s (-1 for none)
  task automatic run(input int b, input int s);
    logic [NUM_CANDS-1:0] eb;
    logic [NUM_CANDS-1:0] es;
    eb = (b < 0) ? '0 : 12'h001 << b;
    es = (s < 0) ? '0 : 12'h001 << s;
    wsu_finder_model_i.send(sg, tk);
    // Taking edge just passed; the word is still inside the pipe
    #1;
    chk(32'(out_valid), 32'h0);
    @(posedge ref_clk);
    #1;
    chk(32'(out_valid), 32'h1);
    chk(32'(best_sel), 32'(eb));
    chk(32'(second_sel), 32'(es));
    chk(32'(best_track), (b < 0) ? 32'h0 : 32'(tk[b]));
    chk(32'(second_track), (s < 0) ? 32'h0 : 32'(tk[s]));
  endtask : run

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic s_regs;
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk(32'(er), 32'h1);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, CTRL_RESET);
    apb(1'b0, OFF_PRIO_MAP, 32'h0);
    chk(rd, PRIO_RESET);
    apb(1'b0, OFF_FND_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, OFF_OUT_CNT, 32'hFFFF_FFFF);
    apb(1'b0, OFF_OUT_CNT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(er), 32'h1);
  endtask : s_regs

  // Quality first, then pt; equal quality resolved by pt
  task automatic s_rank;
    clear();
    tk[3].quality  = 3'h5;
    tk[7].quality  = 3'h5;
    tk[7].pt       = 5'h1F;
    tk[10].quality = 3'h7;
    run(10, 7);
    tk[10].quality = 3'h3;
    run(7, 3);
    clear();
    tk[10].quality = 3'h3;
    run(10, -1);
    clear();
    run(-1, -1);
  endtask : s_rank

  // Shared segment at equal then unequal quality, then split phi at equal quality
  task automatic s_tag;
    clear();
    tk[0].quality  = 3'h4;
    tk[2].quality  = 3'h4;
    sg[0].st3      = 4'h5;
    sg[2].st3      = 4'h5;
    tk[11].quality = 3'h2;
    run(0, 11);
    sg[0].st3 = 4'h0;
    sg[2].st3 = 4'h0;
    sg[2].st4 = 4'h9;
    sg[4].st4 = 4'h9;
    tk[4].quality = 3'h6;
    run(4, 0);
    clear();
    tk[4].quality = 3'h6;
    tk[8].quality = 3'h6;
    tk[4].phi     = 8'h32;
    tk[8].phi     = 8'h33;
    tk[1].quality = 3'h2;
    run(4, 1);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(32'(rd[11:0]), 32'h0000_0100);
  endtask : s_tag

  // Track mask, finder mask, filter, priority map
  task automatic s_mask;
    clear();
    tk[5].quality = 3'h7;
    tk[6].quality = 3'h6;
    tk[9].quality = 3'h5;
    tk[1].quality = 3'h1;
    apb(1'b1, OFF_TRK_MASK, 32'h0000_0020);
    run(6, 9);
    apb(1'b1, OFF_TRK_MASK, 32'h0);
    apb(1'b1, OFF_FND_MASK, 32'h0000_0008);
    run(5, 9);
    apb(1'b1, OFF_FND_MASK, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h0000_0161);
    run(5, 6);
    apb(1'b1, OFF_CTRL, CTRL_RESET);
    apb(1'b1, OFF_PRIO_MAP, 32'h003A_C6B8);
    run(1, 6);
    apb(1'b1, OFF_PRIO_MAP, PRIO_RESET);
  endtask : s_mask

  // Receiver stalls until both buffer entries fill
  task automatic s_stall;
    wsu_track_type [NUM_CANDS-1:0] ta;
    clear();
    tk[0].quality = 3'h2;
    ta = tk;
    @(posedge ref_clk);
    out_ready <= 1'b0;
    wsu_finder_model_i.send(sg, ta);
    tk[11].quality = 3'h3;
    wsu_finder_model_i.send(sg, tk);
    repeat (3) @(posedge ref_clk);
    #1;
    chk(32'(track_ready), 32'h0);
    chk(32'(best_sel), 32'h0000_0001);
    chk(32'(best_track), 32'(ta[0]));
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(32'(rd[STAT_BUF_FULL_BIT]), 32'h1);
    @(posedge ref_clk);
    out_ready <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk(32'(best_sel), 32'h0000_0800);
    chk(32'(second_track), 32'(tk[0]));
    @(posedge ref_clk);
    #1;
    chk(32'(out_valid), 32'h0);
    // Thirteen crossings were sent in all
    apb(1'b0, OFF_OUT_CNT, 32'h0);
    chk(rd, 32'h0000_000D);
  endtask : s_stall

  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    s_regs();
    s_rank();
    s_tag();
    s_mask();
    s_stall();
    test_done();
  end
endmodule : tb
